// ==== rtl/sensor_cfg_pkg.sv ====
package sensor_cfg_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS      = 40;
  localparam int NS_PER_US          = 1000;
  // One output sample at 3.91 kHz is 256 us; slower rates are powers of two of it.
  localparam int OUT_BASE_PERIOD_NS = 256000;
  localparam int OUT_BASE_CYCLES    = OUT_BASE_PERIOD_NS / CLK_PERIOD_NS;
  localparam int RATE_CNT_W         = 17;
  localparam int TICK_CNT_W         = 12;

  // ****************************************************************
  // Word offsets (byte addresses of the command processor)
  // ****************************************************************
  localparam logic [7:0] ADDR_MASKED_ERROR   = 8'h62;
  localparam logic [7:0] ADDR_ERROR_CODE     = 8'h64;
  localparam logic [7:0] ADDR_SELF_TEST      = 8'h66;
  localparam logic [7:0] ADDR_ERROR_ENABLE   = 8'h74;
  localparam logic [7:0] ADDR_COMMUNICATION  = 8'h76;
  localparam logic [7:0] ADDR_OUTPUT         = 8'h78;
  localparam logic [7:0] ADDR_TEMPERATURE    = 8'h7a;
  localparam logic [7:0] ADDR_SENSOR_IF      = 8'h7c;
  localparam logic [7:0] ADDR_DIGITAL        = 8'h7e;
  localparam logic [7:0] ADDR_NONLIN2_TEMP   = 8'h80;
  localparam logic [7:0] ADDR_NONLIN3        = 8'h82;
  localparam logic [7:0] ADDR_NONLIN2        = 8'h84;
  localparam logic [7:0] ADDR_GAIN_TEMP3     = 8'h86;
  localparam logic [7:0] ADDR_GAIN_TEMP2     = 8'h88;

  // ****************************************************************
  // Writable bit masks and reset values
  // ****************************************************************
  localparam logic [15:0] MASK_FULL          = 16'hffff;
  localparam logic [15:0] MASK_DIGITAL       = 16'h070f;
  localparam logic [15:0] MASK_TEMPERATURE   = 16'h007f;
  localparam logic [15:0] MASK_OUTPUT        = 16'h00ff;
  localparam logic [15:0] MASK_COMMUNICATION = 16'h000f;
  localparam logic [15:0] CFG_RESET          = 16'h0000;
  localparam logic [15:0] STATUS_RESET       = 16'h0000;

  // ****************************************************************
  // Command processor modes
  // ****************************************************************
  localparam logic [2:0] MOD_WINDOW    = 3'b000;
  localparam logic [2:0] MOD_SENT_ONLY = 3'b100;
  localparam logic [2:0] MOD_SENT      = 3'b101;
  localparam logic [2:0] MOD_COMMAND   = 3'b110;

  typedef enum logic [2:0] {
    MODE_WINDOW, MODE_SENT_ONLY, MODE_SENT, MODE_COMMAND, MODE_RESERVED
  } comm_mode_e;

  // ****************************************************************
  // Word layouts
  // ****************************************************************
  typedef struct packed {
    logic [4:0] rsvd_hi;
    logic [1:0] sensor_shift_gain;
    logic       nvm_refresh_enable;
    logic [3:0] rsvd_lo;
    logic [1:0] filter_select;
    logic [1:0] sysclk_select;
  } digital_config_s;

  typedef struct packed {
    logic       converter_reference_select;
    logic       input_polarity;
    logic       excitation_type;
    logic       amplifier_offset_sign;
    logic [3:0] amplifier_offset;
    logic [3:0] amplifier_gain;
    logic [3:0] excitation_current_select;
  } sensor_interface_config_s;

  // Pin codes: 00 floating, 01 to negative_excitation, 10 to positive_excitation,
  // 11 to the temperature converter.
  typedef struct packed {
    logic [8:0] rsvd;
    logic       temperature_transmit_enable;
    logic [1:0] temperature_method;
    logic [1:0] temp_sense_pin_b;
    logic [1:0] temp_sense_pin_a;
  } temperature_channel_config_s;

  typedef struct packed {
    logic [7:0] rsvd;
    logic       output_drive_high;
    logic       analog_low_power_enable;
    logic       pause_pulse_disable;
    logic       sensor_pullup_select;
    logic [3:0] tick_period_select;
  } output_config_s;

  typedef struct packed {
    logic [11:0] rsvd;
    logic        read_once;
    logic [2:0]  command_mode_select;
  } communication_config_s;

  // ****************************************************************
  // Carriers
  // ****************************************************************
  typedef struct packed {
    logic       valid;
    logic       write;
    logic [7:0] addr;
    logic [15:0] wdata;
  } cmd_req_s;

  typedef struct packed {
    logic       valid;
    logic       last;
    logic [7:0] addr;
    logic [15:0] data;
  } nvm_word_s;

  typedef struct packed {
    logic [15:0]                  gain_temp2_coeff;
    logic [15:0]                  gain_temp3_coeff;
    logic [15:0]                  nonlin2_coeff;
    logic [15:0]                  nonlin3_coeff;
    logic [15:0]                  nonlin2_temp_coeff;
    digital_config_s              digital_config;
    sensor_interface_config_s     sensor_interface_config;
    temperature_channel_config_s  temperature_channel_config;
    output_config_s               output_config;
    communication_config_s        communication_config;
    logic [15:0]                  error_enable;
    logic [15:0]                  error_code;
    logic [15:0]                  self_test_status;
  } words_s;

  typedef struct packed {
    words_s                w;
    logic                  loading;
    logic [15:0]           rdata;
    logic                  ack;
    logic                  err;
    logic                  fresh;
    logic                  sig_ack;
    logic                  sig_nack;
    logic [TICK_CNT_W-1:0] tick_cnt;
    logic                  tick;
    logic [RATE_CNT_W-1:0] rate_cnt;
    logic                  rate_pulse;
    comm_mode_e            mode;
    logic [15:0]           masked_error;
  } bank_s;

  // Tick length in microseconds for each select code.
  function automatic int tick_us(input logic [3:0] code);
    case (code)
      4'h0: tick_us = 12;
      4'h1: tick_us = 3;
      4'h2: tick_us = 4;
      4'h3: tick_us = 5;
      4'h4: tick_us = 6;
      4'h5: tick_us = 8;
      4'h6: tick_us = 10;
      4'h7: tick_us = 12;
      4'h8: tick_us = 16;
      4'h9: tick_us = 24;
      4'ha: tick_us = 32;
      4'hb: tick_us = 40;
      4'hc: tick_us = 48;
      4'hd: tick_us = 64;
      4'he: tick_us = 80;
      default: tick_us = 90;
    endcase
  endfunction : tick_us

  function automatic logic [TICK_CNT_W-1:0] tick_cycles(input logic [3:0] code);
    tick_cycles = TICK_CNT_W'(tick_us(code) * NS_PER_US / CLK_PERIOD_NS);
  endfunction : tick_cycles

endpackage : sensor_cfg_pkg

// ==== rtl/sensor_config_register_bank.sv ====
// Contract
// - Five 16-bit coefficient words, reset zero.
// - Digital bits 1:0 pick 8/4/2/1 MHz.
// - Digital bits 3:2 pick filter setting.
// - Output rate from clock and filter codes.
// - Digital bit 8 enables memory refresh.
// - Digital bits 10:9 shift gain; rest reserved.
// - Sensor word: current, gain, offset fields.
// - Sensor bit 12 offset sign, 13 excitation.
// - Sensor bit 14 polarity, 15 reference.
// - Two temperature pin fields, four codes each.
// - Temperature bits 5:4 select measurement method.
// - Temperature bit 6 enables temperature transmit.
// - Output bits 3:0 select tick period.
// - Tick period independent of system clock.
// - Output bit 4 pull-up, bit 5 pause.
// - Output bit 6 analog low power.
// - Output bit 7 selects pad drive.
// - Communication bits 2:0 select command mode.
// - Bit 3 read-once refuses stale repeat reads.
// - Status words volatile; masked error read-only.
// - Words loaded from nonvolatile memory after reset.
// - Code 101 is the SENT operational mode.
`timescale 1ns/1ns
`default_nettype none

module sensor_config_register_bank
  import sensor_cfg_pkg::*;
#(
  parameter int OUT_PERIOD_CYCLES = OUT_BASE_CYCLES
) (
  // Clock and reset
  input  wire logic                        core_clk,
  input  wire logic                        arst_n,
  // Command processor word access
  input  wire cmd_req_s                    cmd,
  input  wire logic                        cfg_mode,
  output logic                             cmd_ack,
  output logic                             cmd_err,
  output logic [15:0]                      cmd_rdata,
  // Nonvolatile memory copy stream
  input  wire nvm_word_s                   nvm,
  output logic                             config_loading,
  // Hardware status events
  input  wire logic [15:0]                 error_set,
  input  wire logic [15:0]                 self_test_set,
  // Signal read qualification
  input  wire logic                        new_sample,
  input  wire logic                        signal_read_command,
  output logic                             signal_read_ack,
  output logic                             signal_read_nack,
  // Configuration outputs
  output words_s                           config_words,
  output logic [15:0]                      masked_error_code,
  output comm_mode_e                       command_mode,
  output logic                             out_rate_pulse,
  output logic                             tick_pulse
);

  bank_s st_r;
  bank_s st_nxt;

  // ****************************************************************
  // Word access helpers
  // ****************************************************************
  function automatic logic is_mapped(input logic [7:0] a);
    case (a)
      ADDR_MASKED_ERROR, ADDR_ERROR_CODE, ADDR_SELF_TEST, ADDR_ERROR_ENABLE,
      ADDR_COMMUNICATION, ADDR_OUTPUT, ADDR_TEMPERATURE, ADDR_SENSOR_IF,
      ADDR_DIGITAL, ADDR_NONLIN2_TEMP, ADDR_NONLIN3, ADDR_NONLIN2,
      ADDR_GAIN_TEMP3, ADDR_GAIN_TEMP2: is_mapped = 1'b1;
      default: is_mapped = 1'b0;
    endcase
  endfunction : is_mapped

  function automatic logic [15:0] read_word(input bank_s b, input logic [7:0] a);
    case (a)
      ADDR_MASKED_ERROR:  read_word = b.masked_error;
      ADDR_ERROR_CODE:    read_word = b.w.error_code;
      ADDR_SELF_TEST:     read_word = b.w.self_test_status;
      ADDR_ERROR_ENABLE:  read_word = b.w.error_enable;
      ADDR_COMMUNICATION: read_word = b.w.communication_config;
      ADDR_OUTPUT:        read_word = b.w.output_config;
      ADDR_TEMPERATURE:   read_word = b.w.temperature_channel_config;
      ADDR_SENSOR_IF:     read_word = b.w.sensor_interface_config;
      ADDR_DIGITAL:       read_word = b.w.digital_config;
      ADDR_NONLIN2_TEMP:  read_word = b.w.nonlin2_temp_coeff;
      ADDR_NONLIN3:       read_word = b.w.nonlin3_coeff;
      ADDR_NONLIN2:       read_word = b.w.nonlin2_coeff;
      ADDR_GAIN_TEMP3:    read_word = b.w.gain_temp3_coeff;
      ADDR_GAIN_TEMP2:    read_word = b.w.gain_temp2_coeff;
      default:            read_word = 16'h0000;
    endcase
  endfunction : read_word

  // Volatile status words are only touched when vol is set, so a memory copy
  // can never overwrite them.
  function automatic words_s write_word(input words_s w, input logic [7:0] a,
                                        input logic [15:0] d, input logic vol);
    words_s r;
    r = w;
    case (a)
      ADDR_ERROR_CODE:    if (vol) r.error_code = d;
      ADDR_SELF_TEST:     if (vol) r.self_test_status = d;
      ADDR_ERROR_ENABLE:  r.error_enable = d;
      ADDR_COMMUNICATION: r.communication_config = d & MASK_COMMUNICATION;
      ADDR_OUTPUT:        r.output_config = d & MASK_OUTPUT;
      ADDR_TEMPERATURE:   r.temperature_channel_config = d & MASK_TEMPERATURE;
      ADDR_SENSOR_IF:     r.sensor_interface_config = d & MASK_FULL;
      ADDR_DIGITAL:       r.digital_config = d & MASK_DIGITAL;
      ADDR_NONLIN2_TEMP:  r.nonlin2_temp_coeff = d;
      ADDR_NONLIN3:       r.nonlin3_coeff = d;
      ADDR_NONLIN2:       r.nonlin2_coeff = d;
      ADDR_GAIN_TEMP3:    r.gain_temp3_coeff = d;
      ADDR_GAIN_TEMP2:    r.gain_temp2_coeff = d;
      default:            r = w;
    endcase
    return r;
  endfunction : write_word

  // ****************************************************************
  // Next state
  // ****************************************************************
  logic                  cmd_wr_ok;
  logic                  refresh_on;
  logic [1:0]            rate_shift;
  logic [RATE_CNT_W-1:0] rate_period;
  logic [TICK_CNT_W-1:0] tick_period;

  always_comb begin
    st_nxt         = st_r;
    st_nxt.ack     = 1'b0;
    st_nxt.err     = 1'b0;
    st_nxt.sig_ack = 1'b0;
    st_nxt.sig_nack = 1'b0;
    st_nxt.tick    = 1'b0;
    st_nxt.rate_pulse = 1'b0;

    // Writes from the master are refused while loading or outside
    // configuration mode, and the masked error word never takes a write.
    cmd_wr_ok = cmd.valid && cmd.write && is_mapped(cmd.addr) && !st_r.loading
                && cfg_mode && (cmd.addr != ADDR_MASKED_ERROR);
    if (cmd.valid) begin
      st_nxt.ack   = 1'b1;
      st_nxt.rdata = cmd.write ? 16'h0000 : read_word(st_r, cmd.addr);
      st_nxt.err   = !is_mapped(cmd.addr) || (cmd.write && !cmd_wr_ok);
    end
    if (cmd_wr_ok) begin
      st_nxt.w = write_word(st_r.w, cmd.addr, cmd.wdata, 1'b1);
    end

    // Memory copies land after reset, and again in operational modes when
    // refresh is on; window mode never refreshes.
    refresh_on = st_r.w.digital_config.nvm_refresh_enable
                 && (st_r.mode != MODE_WINDOW);
    if (nvm.valid && (st_r.loading || refresh_on)) begin
      st_nxt.w = write_word(st_nxt.w, nvm.addr, nvm.data, 1'b0);
      if (nvm.last) begin
        st_nxt.loading = 1'b0;
      end
    end

    // Hardware events set status bits after any software write.
    st_nxt.w.error_code       = st_nxt.w.error_code | error_set;
    st_nxt.w.self_test_status = st_nxt.w.self_test_status | self_test_set;
    st_nxt.masked_error       = st_nxt.w.error_code & st_nxt.w.error_enable;

    // A stale repeat read is refused only when read-once is set.
    if (signal_read_command) begin
      st_nxt.sig_nack = st_r.w.communication_config.read_once && !st_r.fresh;
      st_nxt.sig_ack  = !(st_r.w.communication_config.read_once && !st_r.fresh);
      st_nxt.fresh    = 1'b0;
    end
    if (new_sample) begin
      st_nxt.fresh = 1'b1;
    end

    case (st_r.w.communication_config.command_mode_select)
      MOD_WINDOW:    st_nxt.mode = MODE_WINDOW;
      MOD_SENT_ONLY: st_nxt.mode = MODE_SENT_ONLY;
      MOD_SENT:      st_nxt.mode = MODE_SENT;
      MOD_COMMAND:   st_nxt.mode = MODE_COMMAND;
      default:       st_nxt.mode = MODE_RESERVED;
    endcase

    // Tick runs from core_clk directly, so the system clock code has no
    // effect on its length.
    tick_period = tick_cycles(st_r.w.output_config.tick_period_select);
    if (st_r.tick_cnt >= tick_period - 1'b1) begin
      st_nxt.tick_cnt = '0;
      st_nxt.tick     = 1'b1;
    end else begin
      st_nxt.tick_cnt = st_r.tick_cnt + 1'b1;
    end

    // Each step down of the system clock doubles the output period. Filter
    // codes other than 00 win one step back below 8 MHz, paying in accuracy.
    rate_shift = st_r.w.digital_config.sysclk_select;
    if (st_r.w.digital_config.filter_select != 2'b00 && rate_shift != 2'b00) begin
      rate_shift = rate_shift - 2'd1;
    end
    rate_period = RATE_CNT_W'(OUT_PERIOD_CYCLES) << rate_shift;
    if (st_r.rate_cnt >= rate_period - 1'b1) begin
      st_nxt.rate_cnt   = '0;
      st_nxt.rate_pulse = 1'b1;
    end else begin
      st_nxt.rate_cnt = st_r.rate_cnt + 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      st_r <= '{w: '{error_code: STATUS_RESET, self_test_status: STATUS_RESET,
                     default: CFG_RESET},
                loading: 1'b1, mode: MODE_WINDOW, default: '0};
    end else begin
      st_r <= st_nxt;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign cmd_ack           = st_r.ack;
  assign cmd_err           = st_r.err;
  assign cmd_rdata         = st_r.rdata;
  assign config_loading    = st_r.loading;
  assign signal_read_ack   = st_r.sig_ack;
  assign signal_read_nack  = st_r.sig_nack;
  assign config_words      = st_r.w;
  assign masked_error_code = st_r.masked_error;
  assign command_mode      = st_r.mode;
  assign out_rate_pulse    = st_r.rate_pulse;
  assign tick_pulse        = st_r.tick;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  sequence s_cfg_write(logic [7:0] a);
    cmd.valid && cmd.write && cmd.addr == a && cfg_mode && !st_r.loading;
  endsequence

  property p_coef_write;
    s_cfg_write(ADDR_GAIN_TEMP2) |=> cmd_ack && !cmd_err
      && config_words.gain_temp2_coeff == $past(cmd.wdata);
  endproperty
  a_coef_write: assert property (p_coef_write) else $error("coefficient write lost");

  property p_digital_reserved;
    s_cfg_write(ADDR_DIGITAL) |=> 16'(config_words.digital_config)
      == ($past(cmd.wdata) & MASK_DIGITAL);
  endproperty
  a_digital_reserved: assert property (p_digital_reserved) else $error("reserved bits kept");

  property p_masked_ro;
    cmd.valid && cmd.write && cmd.addr == ADDR_MASKED_ERROR
      |=> cmd_err ##1 !cmd_err || cmd.valid;
  endproperty
  a_masked_ro: assert property (p_masked_ro) else $error("masked error word took a write");

  property p_refuse_outside_cfg;
    cmd.valid && cmd.write && !cfg_mode |=> cmd_ack && cmd_err;
  endproperty
  a_refuse_outside_cfg: assert property (p_refuse_outside_cfg) else $error("write outside cfg");

  property p_error_set_wins;
    error_set[0] |=> st_r.w.error_code[0] ##1 masked_error_code[0]
      == (st_r.w.error_code[0] & st_r.w.error_enable[0]);
  endproperty
  a_error_set_wins: assert property (p_error_set_wins) else $error("error event lost");

  property p_read_once;
    signal_read_command && config_words.communication_config.read_once && !st_r.fresh
      |=> signal_read_nack && !signal_read_ack;
  endproperty
  a_read_once: assert property (p_read_once) else $error("stale read acknowledged");

  property p_sent_mode;
    config_words.communication_config.command_mode_select == MOD_SENT [*2]
      |-> command_mode == MODE_SENT;
  endproperty
  a_sent_mode: assert property (p_sent_mode) else $error("mode 101 not decoded");

  // The first tick after a new select code may come early, since the running
  // count is kept; only a tick under a settled code has a known length.
  property p_tick_length;
    tick_pulse && $past(config_words.output_config.tick_period_select)
      == $past(config_words.output_config.tick_period_select, 2)
      |-> $past(st_r.tick_cnt)
      == tick_cycles($past(config_words.output_config.tick_period_select)) - 1'b1
      ##1 (!tick_pulse) [*2];
  endproperty
  a_tick_length: assert property (p_tick_length) else $error("tick period wrong");

  property p_rate_spacing;
    out_rate_pulse |=> !out_rate_pulse [*8];
  endproperty
  a_rate_spacing: assert property (p_rate_spacing) else $error("rate pulses too close");

  property p_load_blocks;
    st_r.loading && cmd.valid && cmd.write |=> cmd_err;
  endproperty
  a_load_blocks: assert property (p_load_blocks) else $error("write during load");

endmodule : sensor_config_register_bank

`default_nettype wire

// ==== bench/nvm_image_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module nvm_image_model
  import sensor_cfg_pkg::*;
(
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic arst_n,
  // Copy stream
  output var nvm_word_s nvm
);
  logic [1:0] idx_r;
  // The image holds a volatile word on purpose, so a bank that stores it is caught.
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      idx_r <= 2'h0;
      nvm   <= '0;
    end else if (idx_r != 2'h3) begin
      idx_r <= idx_r + 2'h1;
      case (idx_r)
        2'h0: nvm <= '{1'b1, 1'b0, ADDR_DIGITAL, 16'hffff};
        2'h1: nvm <= '{1'b1, 1'b0, ADDR_GAIN_TEMP2, 16'ha5a5};
        default: nvm <= '{1'b1, 1'b1, ADDR_SELF_TEST, 16'h1111};
      endcase
    end else begin
      nvm <= '0;
    end
  end
endmodule : nvm_image_model
`default_nettype wire

// ==== bench/sensor_config_register_bank_test.sv ====
`timescale 1ns/1ns
`default_nettype none
module sensor_config_register_bank_test;
  import sensor_cfg_pkg::*;
  localparam int OUT_P = 16;
  logic core_clk = 1'b0, arst_n = 1'b0, cfg_mode = 1'b1, new_sample = 1'b0;
  logic signal_read_command = 1'b0, cmd_ack, cmd_err, config_loading;
  logic signal_read_ack, signal_read_nack, out_rate_pulse, tick_pulse;
  logic [15:0] cmd_rdata, masked_error_code, error_set = '0, self_test_set = '0;
  cmd_req_s cmd = '0;
  nvm_word_s nvm;
  words_s config_words;
  comm_mode_e command_mode;
  int n_errors = 0, checks = 0, cycles = 0, n;
  logic [7:0] adr[13] = '{8'h88, 8'h86, 8'h84, 8'h82, 8'h80, 8'h7e, 8'h7c, 8'h7a, 8'h78,
                          8'h76, 8'h74, 8'h66, 8'h64};
  logic [15:0] msk[13] = '{16'hffff, 16'hffff, 16'hffff, 16'hffff, 16'hffff, 16'h070f,
                           16'hffff, 16'h007f, 16'h00ff, 16'h000f, 16'hffff, 16'hffff, 16'hffff};
  int tk[16] = '{12, 3, 4, 5, 6, 8, 10, 12, 16, 24, 32, 40, 48, 64, 80, 90};
  logic [2:0] mc[5] = '{3'b000, 3'b100, 3'b101, 3'b110, 3'b011};
  comm_mode_e me[5] = '{MODE_WINDOW, MODE_SENT_ONLY, MODE_SENT, MODE_COMMAND, MODE_RESERVED};

  always #(CLK_PERIOD_NS / 2) core_clk = ~core_clk;

  nvm_image_model nvm_u (.core_clk(core_clk), .arst_n(arst_n), .nvm(nvm));

  sensor_config_register_bank #(.OUT_PERIOD_CYCLES(OUT_P)) dut_u (
    .core_clk(core_clk), .arst_n(arst_n), .cmd(cmd), .cfg_mode(cfg_mode), .cmd_ack(cmd_ack),
    .cmd_err(cmd_err), .cmd_rdata(cmd_rdata), .nvm(nvm), .config_loading(config_loading),
    .error_set(error_set), .self_test_set(self_test_set), .new_sample(new_sample),
    .signal_read_command(signal_read_command), .signal_read_ack(signal_read_ack),
    .signal_read_nack(signal_read_nack), .config_words(config_words),
    .masked_error_code(masked_error_code), .command_mode(command_mode),
    .out_rate_pulse(out_rate_pulse), .tick_pulse(tick_pulse));

  // ****************************************************************
  // Access tasks
  // ****************************************************************
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic xfer(input logic w, input logic [7:0] a, input logic [15:0] d,
                      input logic [15:0] exp, input logic e);
    @(posedge core_clk);
    cmd <= '{1'b1, w, a, d};
    @(posedge core_clk);
    cmd <= '0;
    #1;
    chk({15'h0, cmd_ack}, 16'h0001);
    chk({15'h0, cmd_err}, {15'h0, e});
    if (!w) chk(cmd_rdata, exp);
  endtask : xfer

  task automatic sread(input logic [1:0] e);
    @(posedge core_clk);
    signal_read_command <= 1'b1;
    @(posedge core_clk);
    signal_read_command <= 1'b0;
    #1;
    chk({14'h0, signal_read_ack, signal_read_nack}, {14'h0, e});
  endtask : sread

  // The first interval after a change may be partial, so only the second counts.
  task automatic period(input logic sel);
    for (int r = 0; r < 2; r++) begin
      n = 0;
      do begin
        @(posedge core_clk);
        #1;
        n++;
      end while (!(sel ? tick_pulse : out_rate_pulse) && n < 3000);
    end
  endtask : period

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 60000) begin
      n_errors++;
      give_verdict();
    end
  end

  initial begin
    repeat (12) @(posedge core_clk);
    arst_n <= 1'b1;
    xfer(1'b1, ADDR_NONLIN3, 16'h1234, 16'h0, 1'b1);
    repeat (4) @(posedge core_clk);
    #1;
    chk({15'h0, config_loading}, 16'h0);
    xfer(1'b0, ADDR_DIGITAL, 16'h0, 16'h070f, 1'b0);
    xfer(1'b0, ADDR_GAIN_TEMP2, 16'h0, 16'ha5a5, 1'b0);
    xfer(1'b0, ADDR_SELF_TEST, 16'h0, 16'h0, 1'b0);
    xfer(1'b0, ADDR_GAIN_TEMP3, 16'h0, 16'h0, 1'b0);
    xfer(1'b0, ADDR_NONLIN3, 16'h0, 16'h0, 1'b0);
    $display("load test done");
    for (int i = 0; i < 13; i++) begin
      xfer(1'b1, adr[i], 16'hffff, 16'h0, 1'b0);
      xfer(1'b0, adr[i], 16'h0, msk[i], 1'b0);
    end
    xfer(1'b1, ADDR_MASKED_ERROR, 16'h1234, 16'h0, 1'b1);
    xfer(1'b0, 8'h70, 16'h0, 16'h0, 1'b1);
    @(posedge core_clk) cfg_mode <= 1'b0;
    xfer(1'b1, ADDR_NONLIN2, 16'h1111, 16'h0, 1'b1);
    @(posedge core_clk) cfg_mode <= 1'b1;
    xfer(1'b0, ADDR_NONLIN2, 16'h0, 16'hffff, 1'b0);
    xfer(1'b1, ADDR_SENSOR_IF, 16'h5a3c, 16'h0, 1'b0);
    chk(config_words.sensor_interface_config, 16'h5a3c);
    xfer(1'b1, ADDR_TEMPERATURE, 16'h0059, 16'h0, 1'b0);
    chk(config_words.temperature_channel_config, 16'h0059);
    xfer(1'b1, ADDR_OUTPUT, 16'h00b5, 16'h0, 1'b0);
    chk(config_words.output_config, 16'h00b5);
    $display("register test done");
    for (int i = 0; i < 5; i++) begin
      xfer(1'b1, ADDR_COMMUNICATION, {13'h0, mc[i]}, 16'h0, 1'b0);
      @(posedge core_clk);
      #1;
      chk({13'h0, command_mode}, {13'h0, me[i]});
    end
    xfer(1'b1, ADDR_COMMUNICATION, 16'h0008, 16'h0, 1'b0);
    @(posedge core_clk) new_sample <= 1'b1;
    @(posedge core_clk) new_sample <= 1'b0;
    sread(2'b10);
    sread(2'b01);
    xfer(1'b1, ADDR_COMMUNICATION, 16'h0000, 16'h0, 1'b0);
    sread(2'b10);
    xfer(1'b1, ADDR_ERROR_CODE, 16'h0, 16'h0, 1'b0);
    xfer(1'b1, ADDR_ERROR_ENABLE, 16'h0005, 16'h0, 1'b0);
    @(posedge core_clk) error_set <= 16'h0007;
    @(posedge core_clk) error_set <= 16'h0;
    xfer(1'b0, ADDR_ERROR_CODE, 16'h0, 16'h0007, 1'b0);
    xfer(1'b0, ADDR_MASKED_ERROR, 16'h0, 16'h0005, 1'b0);
    chk(masked_error_code, 16'h0005);
    fork
      xfer(1'b1, ADDR_SELF_TEST, 16'h0, 16'h0, 1'b0);
      begin
        @(posedge core_clk) self_test_set <= 16'h0100;
        @(posedge core_clk) self_test_set <= 16'h0;
      end
    join
    xfer(1'b0, ADDR_SELF_TEST, 16'h0, 16'h0100, 1'b0);
    $display("status test done");
    for (int c = 0; c < 16; c++) begin
      xfer(1'b1, ADDR_DIGITAL, 16'(c & 3), 16'h0, 1'b0);
      xfer(1'b1, ADDR_OUTPUT, 16'(c), 16'h0, 1'b0);
      period(1'b1);
      chk(16'(n), 16'(tk[c] * NS_PER_US / CLK_PERIOD_NS));
    end
    for (int c = 0; c < 16; c++) begin
      xfer(1'b1, ADDR_DIGITAL, 16'(c), 16'h0, 1'b0);
      period(1'b0);
      chk(16'(n), 16'(OUT_P << ((c % 4 == 0) ? 0 : (c % 4) - 1 + (c < 4))));
    end
    $display("timing test done");
    give_verdict();
  end
endmodule : sensor_config_register_bank_test
`default_nettype wire
